// File: verilog/output_gate_sync.sv
// Output gate and linked turn-on logic behind two rear port pins, with Wishbone registers
// How it works
// - In level-gate mode, non-inverted, a low gate pin while enabled forces the output to zero but keeps the enable and its indicator on.
// - In level-gate mode the output comes back by itself as soon as the gate pin is inactive again.
// - A floating gate pin reads high, which in non-inverted use is inactive and changes nothing.
// - With the gate pin inverted, a high level is the one that suppresses the output.
// - Each pin has its own invert bit that applies to what it receives and to what it drives.
// - While the level gate suppresses the output a gate-active indication is raised and the output stays off.
// - The gate pin can be switched from level-gate mode to pulse-trip mode.
// - In pulse-trip mode a valid pulse while enabled clears the enable, so output and indicator go off.
// - A trip sets a protection flag and keeps the output off until software clears it and enables again.
// - In linked turn-on mode the link pin both receives and drives pulses.
// - In linked turn-on mode each off-to-on change of the enable that comes while no pulse is going out sends one pulse out on the link pin.
// - A link pulse received while already enabled leaves the enable alone and only raises the link-receive event.
// - A link pulse received while disabled turns the enable on, unless the protection flag stands.
// - In general output use a pin drives a constant one, a constant zero or a PWM waveform.
//
// Implementation choices: the Wishbone register port and the register offsets.
`default_nettype none

module output_gate_sync #(
	parameter int unsigned PULSE_CYC = gate_sync_pkg::PULSE_MIN_CYC,
	parameter int unsigned DIV_CYC   = gate_sync_pkg::PWM_DIV
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone slave
	input  wire gate_sync_pkg::wb_req_s wb_i,
	output gate_sync_pkg::wb_rsp_s      wb_o,
	// Gate pin
	input  wire logic                   gate_pin_i,
	output logic                        gate_pin_o,
	output logic                        gate_pin_oe_o,
	// Link pin
	input  wire logic                   link_pin_i,
	output logic                        link_pin_o,
	output logic                        link_pin_oe_o,
	// Instrument state
	output logic                        output_enable_o,
	output logic                        actual_output_on_o,
	output logic                        gate_active_indicator_o,
	output logic                        trip_protect_flag_o,
	// Interrupt
	output logic                        irq_o
);
	import gate_sync_pkg::*;

	localparam int unsigned GATE = 0;
	localparam int unsigned LINK = 1;
	localparam logic [PCNT_W-1:0] PULSE_LAST = PCNT_W'(PULSE_CYC - 1);
	localparam logic [DIV_W-1:0]  DIV_LAST   = DIV_W'(DIV_CYC - 1);

	typedef struct packed {
		logic [CTRL_W-1:0]        ctrl;
		logic                     out_en;
		logic                     prev_en;
		logic                     trip;
		logic                     gate_act;
		logic                     act_on;
		logic [IRQ_W-1:0]         irq_stat;
		logic [IRQ_W-1:0]         irq_mask;
		logic                     irq;
		logic [31:0]              gate_pwm;
		logic [31:0]              link_pwm;
		wb_rsp_s                  rsp;
		logic [1:0]               sync1;
		logic [1:0]               sync2;
		logic [1:0][PCNT_W-1:0]   flt_cnt;
		logic [1:0]               flt_done;
		logic                     tx_busy;
		logic [PCNT_W-1:0]        tx_cnt;
		pin_drv_s                 gate_drv;
		pin_drv_s                 link_drv;
		logic [DIV_W-1:0]         div_cnt;
		logic                     tick;
	} state_s;

	state_s st_ff;
	state_s nxt_st;

	logic gate_pwm_val;
	logic link_pwm_val;

	// ==========================================================
	// PWM sources for general output use
	pwm_gen u_gate_pwm (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.tick_i   (st_ff.tick),
		.period_i (st_ff.gate_pwm[PWM_W-1:0]),
		.duty_i   (st_ff.gate_pwm[PWM_DUTY_LSB +: PWM_W]),
		.pwm_o    (gate_pwm_val)
	);

	pwm_gen u_link_pwm (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.tick_i   (st_ff.tick),
		.period_i (st_ff.link_pwm[PWM_W-1:0]),
		.duty_i   (st_ff.link_pwm[PWM_DUTY_LSB +: PWM_W]),
		.pwm_o    (link_pwm_val)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	// Logical one drives the active (low) level unless the pin is inverted
	function automatic logic pin_level(input logic val, input logic inv);
		return ~val ^ inv;
	endfunction : pin_level

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic        req;
		logic        wr;
		logic        en_on_cmd;
		logic        en_off_cmd;
		logic        clr_trip;
		logic [31:0] wdat;
		logic [1:0]  act_lvl;
		logic [1:0]  rx_pulse;
		logic        gate_inv;
		logic        link_inv;
		logic        pulse_mode;
		pin_fn_e     gate_fn;
		pin_fn_e     link_fn;
		logic        gate_special;
		logic        link_special;
		logic        trip_ev;
		logic        link_on_ev;
		logic        gate_lvl_act;
		logic        gen_val;

		nxt_st       = st_ff;
		req          = 1'b0;
		wr           = 1'b0;
		en_on_cmd    = 1'b0;
		en_off_cmd   = 1'b0;
		clr_trip     = 1'b0;
		wdat         = '0;
		act_lvl      = '0;
		rx_pulse     = '0;
		gate_inv     = st_ff.ctrl[CTRL_GATE_INV];
		link_inv     = st_ff.ctrl[CTRL_LINK_INV];
		pulse_mode   = st_ff.ctrl[CTRL_PULSE_MODE];
		gate_fn      = pin_fn_e'(st_ff.ctrl[CTRL_GATE_FN +: 2]);
		link_fn      = pin_fn_e'(st_ff.ctrl[CTRL_LINK_FN +: 2]);
		gate_special = (gate_fn == FN_SPECIAL);
		link_special = (link_fn == FN_SPECIAL);
		trip_ev      = 1'b0;
		link_on_ev   = 1'b0;
		gate_lvl_act = 1'b0;
		gen_val      = 1'b0;

		// ======================================================
		// Input synchronisers and width filters
		nxt_st.sync1 = {link_pin_i, gate_pin_i};
		nxt_st.sync2 = st_ff.sync1;
		// Active level is low unless inverted; our own drive is not heard as input
		act_lvl[GATE] = ~(st_ff.sync2[GATE] ^ gate_inv);
		act_lvl[LINK] = ~(st_ff.sync2[LINK] ^ link_inv) & ~st_ff.tx_busy;
		for (int p = 0; p < 2; p++) begin
			if (!act_lvl[p]) begin
				nxt_st.flt_cnt[p]  = '0;
				nxt_st.flt_done[p] = 1'b0;
			end else if (st_ff.flt_cnt[p] < PULSE_LAST) begin
				nxt_st.flt_cnt[p] = st_ff.flt_cnt[p] + PCNT_W'(1);
			end else if (!st_ff.flt_done[p]) begin
				// One pulse per active phase, however long it stays
				rx_pulse[p]        = 1'b1;
				nxt_st.flt_done[p] = 1'b1;
			end
		end

		// ======================================================
		// Wishbone slave: one wait state, ack for one cycle
		req        = wb_i.cyc && wb_i.stb && !st_ff.rsp.ack;
		wr         = req && wb_i.we;
		nxt_st.rsp.ack = req;
		wdat       = wb_i.dat;
		if (req) begin
			case ({wb_i.adr[7:2], 2'b00})
				REG_CTRL:       nxt_st.rsp.dat = {25'h0, st_ff.ctrl};
				REG_ENABLE:     nxt_st.rsp.dat = {31'h0, st_ff.out_en};
				REG_STATE:      nxt_st.rsp.dat = {24'h0, 1'b0, st_ff.sync2, st_ff.tx_busy,
					st_ff.trip, st_ff.gate_act, st_ff.act_on, st_ff.out_en};
				REG_IRQ_STATUS: nxt_st.rsp.dat = {29'h0, st_ff.irq_stat};
				REG_IRQ_MASK:   nxt_st.rsp.dat = {29'h0, st_ff.irq_mask};
				REG_GATE_PWM:   nxt_st.rsp.dat = st_ff.gate_pwm;
				REG_LINK_PWM:   nxt_st.rsp.dat = st_ff.link_pwm;
				default:        nxt_st.rsp.dat = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			case ({wb_i.adr[7:2], 2'b00})
				REG_CTRL: begin
					if (wb_i.sel[0]) begin
						nxt_st.ctrl = wdat[CTRL_W-1:0];
					end
				end
				REG_ENABLE: begin
					if (wb_i.sel[0]) begin
						// Turning on is refused while the protection flag stands
						en_on_cmd  = wdat[EN_ON] && !st_ff.trip;
						en_off_cmd = !wdat[EN_ON];
						clr_trip   = wdat[EN_CLR_TRIP];
					end
				end
				REG_IRQ_MASK: begin
					if (wb_i.sel[0]) begin
						nxt_st.irq_mask = wdat[IRQ_W-1:0];
					end
				end
				REG_GATE_PWM: nxt_st.gate_pwm = merge_bytes(st_ff.gate_pwm, wdat, wb_i.sel);
				REG_LINK_PWM: nxt_st.link_pwm = merge_bytes(st_ff.link_pwm, wdat, wb_i.sel);
				default: begin
				end
			endcase
		end

		// ======================================================
		// Enable state, trip and link turn-on
		trip_ev = gate_special && pulse_mode && rx_pulse[GATE] && st_ff.out_en;
		// A link pulse turns on only from off and never past a standing trip
		link_on_ev = link_special && rx_pulse[LINK] && !st_ff.out_en
			&& !st_ff.trip;
		if (trip_ev) begin
			nxt_st.out_en = 1'b0;
		end else if (en_off_cmd) begin
			nxt_st.out_en = 1'b0;
		end else if (en_on_cmd || link_on_ev) begin
			nxt_st.out_en = 1'b1;
		end
		// Set wins over a clear in the same cycle
		if (trip_ev) begin
			nxt_st.trip = 1'b1;
		end else if (clr_trip) begin
			nxt_st.trip = 1'b0;
		end

		// Level gate leaves the enable alone and only masks the actual output
		gate_lvl_act    = gate_special && !pulse_mode && act_lvl[GATE];
		nxt_st.gate_act = gate_lvl_act && nxt_st.out_en;
		nxt_st.act_on   = nxt_st.out_en && !gate_lvl_act;

		// ======================================================
		// Link pulse transmitter
		nxt_st.prev_en = st_ff.out_en;
		if (st_ff.tx_busy) begin
			if (st_ff.tx_cnt >= PULSE_LAST) begin
				nxt_st.tx_busy = 1'b0;
			end else begin
				nxt_st.tx_cnt = st_ff.tx_cnt + PCNT_W'(1);
			end
		end else if (link_special && st_ff.out_en && !st_ff.prev_en) begin
			nxt_st.tx_busy = 1'b1;
			nxt_st.tx_cnt  = '0;
		end

		// ======================================================
		// Pin drivers
		case (gate_fn)
			FN_ONE:  gen_val = 1'b1;
			FN_ZERO: gen_val = 1'b0;
			FN_PWM:  gen_val = gate_pwm_val;
			default: gen_val = 1'b0;
		endcase
		nxt_st.gate_drv.oe = !gate_special;
		nxt_st.gate_drv.o  = !gate_special && pin_level(gen_val, gate_inv);
		case (link_fn)
			FN_ONE:  gen_val = 1'b1;
			FN_ZERO: gen_val = 1'b0;
			FN_PWM:  gen_val = link_pwm_val;
			default: gen_val = 1'b1;
		endcase
		if (link_special) begin
			// Released between pulses so the far end may drive the line
			nxt_st.link_drv.oe = nxt_st.tx_busy;
			nxt_st.link_drv.o  = nxt_st.tx_busy && pin_level(1'b1, link_inv);
		end else begin
			nxt_st.link_drv.oe = 1'b1;
			nxt_st.link_drv.o  = pin_level(gen_val, link_inv);
		end

		// ======================================================
		// PWM rate divider
		if (st_ff.div_cnt >= DIV_LAST) begin
			nxt_st.div_cnt = '0;
			nxt_st.tick    = 1'b1;
		end else begin
			nxt_st.div_cnt = st_ff.div_cnt + DIV_W'(1);
			nxt_st.tick    = 1'b0;
		end

		// ======================================================
		// Sticky events: write one clears, a new event in the same cycle wins
		if (wr && {wb_i.adr[7:2], 2'b00} == REG_IRQ_STATUS && wb_i.sel[0]) begin
			nxt_st.irq_stat = st_ff.irq_stat & ~wdat[IRQ_W-1:0];
		end
		if (trip_ev) begin
			nxt_st.irq_stat[IRQ_TRIP] = 1'b1;
		end
		if (nxt_st.gate_act && !st_ff.gate_act) begin
			nxt_st.irq_stat[IRQ_GATE] = 1'b1;
		end
		if (link_special && rx_pulse[LINK]) begin
			nxt_st.irq_stat[IRQ_LINK_RX] = 1'b1;
		end
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff          <= '0;
			st_ff.ctrl     <= CTRL_RST;
			st_ff.irq_mask <= MASK_RST;
			st_ff.gate_pwm <= PWM_RST;
			st_ff.link_pwm <= PWM_RST;
			st_ff.sync1    <= 2'h3;
			st_ff.sync2    <= 2'h3;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs, all straight from the state register
	assign wb_o                    = st_ff.rsp;
	assign gate_pin_o              = st_ff.gate_drv.o;
	assign gate_pin_oe_o           = st_ff.gate_drv.oe;
	assign link_pin_o              = st_ff.link_drv.o;
	assign link_pin_oe_o           = st_ff.link_drv.oe;
	assign output_enable_o         = st_ff.out_en;
	assign actual_output_on_o      = st_ff.act_on;
	assign gate_active_indicator_o = st_ff.gate_act;
	assign trip_protect_flag_o     = st_ff.trip;
	assign irq_o                   = st_ff.irq;

endmodule : output_gate_sync

`default_nettype wire

// File: verilog/gate_sync_pkg.sv
// Shared constants, register map and carrier types for the output gate and link block
`default_nettype none

package gate_sync_pkg;

	// ==========================================================
	// Clock and pulse timing
	localparam int unsigned CLK_FREQ_MHZ  = 125;
	localparam int unsigned PULSE_MIN_NS  = 30000;
	// Least time, so round up to whole cycles
	localparam int unsigned PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int unsigned PCNT_W        = 12;
	localparam int unsigned PWM_DIV       = 125;
	localparam int unsigned DIV_W         = 8;
	localparam int unsigned PWM_W         = 16;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] REG_CTRL       = 8'h00;
	localparam logic [7:0] REG_ENABLE     = 8'h04;
	localparam logic [7:0] REG_STATE      = 8'h08;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h10;
	localparam logic [7:0] REG_GATE_PWM   = 8'h14;
	localparam logic [7:0] REG_LINK_PWM   = 8'h18;

	// ==========================================================
	// Field positions
	localparam int unsigned CTRL_W          = 7;
	localparam int unsigned CTRL_PULSE_MODE = 0;
	localparam int unsigned CTRL_GATE_INV   = 1;
	localparam int unsigned CTRL_LINK_INV   = 2;
	localparam int unsigned CTRL_GATE_FN    = 3;
	localparam int unsigned CTRL_LINK_FN    = 5;
	localparam int unsigned EN_ON           = 0;
	localparam int unsigned EN_CLR_TRIP     = 1;
	localparam int unsigned IRQ_W           = 3;
	localparam int unsigned IRQ_TRIP        = 0;
	localparam int unsigned IRQ_GATE        = 1;
	localparam int unsigned IRQ_LINK_RX     = 2;
	localparam int unsigned PWM_DUTY_LSB    = 16;

	// ==========================================================
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	localparam logic [IRQ_W-1:0]  MASK_RST = 3'h0;
	localparam logic [31:0]       PWM_RST  = 32'h0000_0000;

	// ==========================================================
	// Pin function select
	typedef enum logic [1:0] {
		FN_SPECIAL = 2'h0,
		FN_ONE     = 2'h1,
		FN_ZERO    = 2'h2,
		FN_PWM     = 2'h3
	} pin_fn_e;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_s;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_s;

	typedef struct packed {
		logic o;
		logic oe;
	} pin_drv_s;

	typedef struct packed {
		logic [PWM_W-1:0] cnt;
		logic             out;
	} pwm_state_s;

endpackage : gate_sync_pkg

`default_nettype wire

// File: verilog/pwm_gen.sv
// Tick-driven PWM generator for one port pin in general output use
`default_nettype none

module pwm_gen (
	// Clock and reset
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	// Rate and shape
	input  wire logic                           tick_i,
	input  wire logic [gate_sync_pkg::PWM_W-1:0] period_i,
	input  wire logic [gate_sync_pkg::PWM_W-1:0] duty_i,
	// Waveform, logical one during the duty part
	output logic                                pwm_o
);
	import gate_sync_pkg::*;

	pwm_state_s st_ff;
	pwm_state_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (tick_i) begin
			// A period of zero or one still gives a defined waveform
			if (st_ff.cnt >= period_i - PWM_W'(1) || period_i == '0) begin
				nxt_st.cnt = '0;
			end else begin
				nxt_st.cnt = st_ff.cnt + PWM_W'(1);
			end
		end
		nxt_st.out = (st_ff.cnt < duty_i);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pwm_o = st_ff.out;

endmodule : pwm_gen

`default_nettype wire

// File: dv/gate_sync_checker.sv
// Assertions on the ports of the output gate and link block
`default_nettype none

module gate_sync_checker #(
	parameter int unsigned PULSE_CYC = gate_sync_pkg::PULSE_MIN_CYC
) (
	// Clock and reset
	input wire logic                    clk_i,
	input wire logic                    rst_i,
	// Bus
	input wire gate_sync_pkg::wb_req_s  wb_i,
	input wire gate_sync_pkg::wb_rsp_s  wb_o,
	// Pins and state
	input wire logic                    gate_pin_i,
	input wire logic                    link_pin_oe_o,
	input wire logic                    output_enable_o,
	input wire logic                    actual_output_on_o,
	input wire logic                    gate_active_indicator_o,
	input wire logic                    trip_protect_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_ack_one_cycle: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("ack held longer than one cycle");
	a_ack_after_take: assert property (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
		else $error("request not answered in the next cycle");
	a_ack_needs_req: assert property (wb_o.ack |-> $past(wb_i.cyc && wb_i.stb))
		else $error("ack without a request");
	a_gate_keeps_on: assert property ($rose(gate_active_indicator_o) |-> output_enable_o)
		else $error("gate suppression without enable");
	a_gate_hides_out: assert property (gate_active_indicator_o |-> !actual_output_on_o)
		else $error("output delivered while gated");
	a_gate_restore: assert property ($fell(gate_active_indicator_o) && output_enable_o |-> actual_output_on_o)
		else $error("output not restored after gate release");
	a_trip_keeps_off: assert property (trip_protect_flag_o && $past(trip_protect_flag_o) |-> !output_enable_o && !actual_output_on_o)
		else $error("output on while trip flag held");
	// A trip needs the pin at the same level 4 and 9 cycles before the flag rises
	a_trip_min_pulse: assert property ($rose(trip_protect_flag_o) |-> $past(gate_pin_i, 4) == $past(gate_pin_i, 9))
		else $error("trip taken from a short glitch");
	a_link_tx_cause: assert property ($rose(link_pin_oe_o) |-> $past(output_enable_o))
		else $error("link pulse without an enable");
	a_link_tx_width: assert property ($rose(link_pin_oe_o) |-> link_pin_oe_o [*8])
		else $error("link pulse too short");

	c_trip: cover property ($rose(trip_protect_flag_o));
	c_gate: cover property ($rose(gate_active_indicator_o));
	c_link_tx: cover property ($rose(link_pin_oe_o));
endmodule : gate_sync_checker

bind output_gate_sync gate_sync_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk_i, .rst_i, .wb_i,
	.wb_o, .gate_pin_i, .link_pin_oe_o, .output_enable_o, .actual_output_on_o,
	.gate_active_indicator_o, .trip_protect_flag_o);

`default_nettype wire

// File: dv/ext_peer.sv
// Peer instrument model: pulls the gate and link wires, measures link pulses
`default_nettype none

module ext_peer #(
	parameter int unsigned MIN_CYC = 8
) (
	// Clock
	input  wire logic clk_i,
	// Device pin drivers
	input  wire logic gate_pin_o,
	input  wire logic gate_pin_oe_o,
	input  wire logic link_pin_o,
	input  wire logic link_pin_oe_o,
	// Resolved wires
	output logic      gate_wire_o,
	output logic      link_wire_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic gate_drv = 1'b1;
	logic link_drv = 1'b1;
	int   width    = 0;
	int   tx_ok    = 0;
	int   tx_short = 0;

	// ==========================================================
	// Wires with pull-ups; a released or unconnected line reads high
	assign gate_wire_o = (gate_pin_oe_o ? gate_pin_o : 1'b1) & gate_drv;
	assign link_wire_o = (link_pin_oe_o ? link_pin_o : 1'b1) & link_drv;

	// Hold one level for a number of cycles, then return to the other
	task automatic pulse(input bit on_link, input logic lvl, input int cyc);
		if (on_link)
			link_drv <= lvl;
		else
			gate_drv <= lvl;
		repeat (cyc) @(posedge clk_i);
		if (on_link)
			link_drv <= ~lvl;
		else
			gate_drv <= ~lvl;
	endtask : pulse

	// ==========================================================
	// Low time of each pulse the device sends on the link
	always @(posedge clk_i) begin
		if (link_pin_oe_o && link_wire_o === 1'b0)
			width <= width + 1;
		else if (width != 0) begin
			if (width >= MIN_CYC)
				tx_ok <= tx_ok + 1;
			else
				tx_short <= tx_short + 1;
			width <= 0;
		end
	end
endmodule : ext_peer

`default_nettype wire

// File: dv/output_gate_sync_tb.sv
// Self-checking bench for the output gate and linked turn-on block
`default_nettype none

module output_gate_sync_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gate_sync_pkg::*;

	// Short pulse qualification keeps the run brief
	localparam int unsigned PC = 8;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	wb_req_s     wb_i  = '0;
	wb_rsp_s     wb_o;
	logic        gate_i, gate_o, gate_oe, link_i, link_o, link_oe;
	logic        en, act, gact, trip, irq;
	logic [31:0] exp_q[$];
	logic [31:0] d;
	int          failures        = 0;
	int          samples_checked = 0;
	int          seed            = 59788;
	int          cycles          = 0;
	int          n;

	always #4 clk_i = ~clk_i;

	output_gate_sync #(.PULSE_CYC(PC), .DIV_CYC(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_i(wb_i), .wb_o(wb_o), .gate_pin_i(gate_i), .gate_pin_o(gate_o),
		.gate_pin_oe_o(gate_oe), .link_pin_i(link_i), .link_pin_o(link_o),
		.link_pin_oe_o(link_oe), .output_enable_o(en), .actual_output_on_o(act),
		.gate_active_indicator_o(gact), .trip_protect_flag_o(trip), .irq_o(irq));

	ext_peer #(.MIN_CYC(PC)) u_peer (.clk_i(clk_i), .gate_pin_o(gate_o),
		.gate_pin_oe_o(gate_oe), .link_pin_o(link_o), .link_pin_oe_o(link_oe),
		.gate_wire_o(gate_i), .link_wire_o(link_i));

	// ==========================================================
	// Comparison, bus cycles and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
		wb_i <= '{1'b1, 1'b1, we, a, 4'hf, dat};
		do @(posedge clk_i); while (wb_o.ack !== 1'b1);
		wb_i <= '0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd

	task automatic idle(input int k);
		repeat (k) @(posedge clk_i);
	endtask : idle

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : summarize

	// Read data is matched against the oldest note at the ack edge
	always @(posedge clk_i) begin
		if (wb_o.ack === 1'b1 && wb_i.we === 1'b0)
			check(wb_o.dat, exp_q.pop_front());
	end

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end

	// ==========================================================
	// Scenarios
	initial begin
		idle(10);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(REG_CTRL, 32'h0);
		rd(REG_IRQ_MASK, 32'h0);
		rd(REG_STATE, 32'h60);
		wb(1'b1, 8'h1c, 32'hffff_ffff);
		rd(8'h1c, 32'h0);
		repeat (4) begin
			d = $random(seed);
			wb(1'b1, REG_LINK_PWM, d);
			rd(REG_LINK_PWM, d);
		end
		// General output: constants in both polarities, then PWM
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, REG_CTRL, (i[0] ? 32'h10 : 32'h08) | (i[1] ? 32'h2 : 32'h0));
			idle(4);
			check({30'h0, gate_oe, gate_o}, {30'h0, 1'b1, i[0] ^ i[1]});
		end
		wb(1'b1, REG_GATE_PWM, 32'h0002_0004);
		wb(1'b1, REG_CTRL, 32'h18);
		idle(8);
		n = 0;
		repeat (16) begin
			@(posedge clk_i);
			n += (gate_o === 1'b0);
		end
		check(32'(n), 32'd8);
		// Level gate, plain then inverted
		wb(1'b1, REG_CTRL, 32'h0);
		wb(1'b1, REG_ENABLE, 32'h1);
		idle(20);
		rd(REG_STATE, 32'h63);
		u_peer.gate_drv <= 1'b0;
		idle(5);
		rd(REG_STATE, 32'h45);
		check({28'h0, trip, gact, act, en}, 32'h5);
		u_peer.gate_drv <= 1'b1;
		idle(5);
		rd(REG_STATE, 32'h63);
		check({28'h0, trip, gact, act, en}, 32'h3);
		wb(1'b1, REG_CTRL, 32'h2);
		idle(5);
		rd(REG_STATE, 32'h65);
		u_peer.gate_drv <= 1'b0;
		idle(5);
		rd(REG_STATE, 32'h43);
		u_peer.gate_drv <= 1'b1;
		// Pulse trip: a glitch first, then a full pulse
		wb(1'b1, REG_CTRL, 32'h1);
		u_peer.pulse(1'b0, 1'b0, PC - 3);
		idle(20);
		rd(REG_STATE, 32'h63);
		u_peer.pulse(1'b0, 1'b0, PC + 2);
		idle(20);
		rd(REG_STATE, 32'h68);
		check({28'h0, trip, gact, act, en}, 32'h8);
		wb(1'b1, REG_ENABLE, 32'h1);
		idle(20);
		rd(REG_STATE, 32'h68);
		wb(1'b1, REG_ENABLE, 32'h2);
		wb(1'b1, REG_ENABLE, 32'h1);
		// Linked turn-on in both directions
		wb(1'b1, REG_CTRL, 32'h0);
		idle(20);
		check(32'(u_peer.tx_ok), 32'd2);
		u_peer.pulse(1'b1, 1'b0, PC + 2);
		idle(20);
		rd(REG_STATE, 32'h63);
		check(32'(u_peer.tx_ok), 32'd2);
		wb(1'b1, REG_ENABLE, 32'h0);
		u_peer.pulse(1'b1, 1'b0, PC + 2);
		idle(20);
		rd(REG_STATE, 32'h63);
		check(32'(u_peer.tx_ok), 32'd3);
		check(32'(u_peer.tx_short), 32'd0);
		// Sticky events, mask and write-one-to-clear
		rd(REG_IRQ_STATUS, 32'h7);
		check({31'h0, irq}, 32'h0);
		wb(1'b1, REG_IRQ_MASK, 32'h2);
		idle(2);
		check({31'h0, irq}, 32'h1);
		wb(1'b1, REG_IRQ_STATUS, 32'h2);
		idle(2);
		check({31'h0, irq}, 32'h0);
		rd(REG_IRQ_STATUS, 32'h5);
		// Link pin in general output use, both polarities, kept enabled so no tx is implied
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, REG_CTRL, (i[0] ? 32'h40 : 32'h20) | (i[1] ? 32'h4 : 32'h0));
			idle(4);
			check({30'h0, link_oe, link_o}, {30'h0, 1'b1, i[0] ^ i[1]});
		end
		summarize();
	end
endmodule : output_gate_sync_tb

`default_nettype wire
